/* File: logic/ebr_map.vh */
`ifndef EBR_MAP_VH
`define EBR_MAP_VH
// Power-on initialization interval, in microseconds
`define EBR_INIT_US 100
// Clock rate in MHz
`define EBR_CLK_MHZ 40
// Cycles of the initialization interval
`define EBR_INIT_CYC (`EBR_INIT_US * `EBR_CLK_MHZ)
// Bits per byte before the acknowledge slot
`define EBR_BYTE_BITS 4'h8
// Protocol states
`define EBR_ST_STANDBY 3'h0
`define EBR_ST_ADDR 3'h1
`define EBR_ST_ADDR_ACK 3'h2
`define EBR_ST_WRITE 3'h3
`define EBR_ST_WRITE_ACK 3'h4
`define EBR_ST_READ 3'h5
`define EBR_ST_READ_ACK 3'h6
`define EBR_ST_IGNORE 3'h7
`endif

/* File: logic/ebr_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser with registered edge detect on the second stage
module ebr_sync (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Asynchronous pin level
	input wire pin_in,
	// Synchronised level and edges
	output reg level_reg,
	output wire rise,
	output wire fall
);
	reg meta_reg;
	reg prev_reg;

	// Sync chain, idle high like a pulled-up bus line
	always @(posedge clk) begin
		if (!rstn) begin
			meta_reg <= 1'b1;
			level_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pin_in;
			level_reg <= meta_reg;
			prev_reg <= level_reg;
		end
	end

	assign rise = level_reg & ~prev_reg;
	assign fall = ~level_reg & prev_reg;
endmodule

/* File: logic/ebr_core.v */
`timescale 1ns/1ps
`include "ebr_map.vh"

module ebr_core #(
	parameter INIT_CYCLES = `EBR_INIT_CYC,
	parameter [6:0] DEV_ADDR = 7'h50,
	parameter [7:0] READ_BYTE = 8'hA5
) (
	// Clock and power-on-clear reset
	input wire clk,
	input wire rstn,
	// Bus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// Status
	output reg init_done,
	output reg standby,
	output reg wr_commit,
	output reg [7:0] wr_data
);
	wire scl_lvl;
	wire scl_rise;
	wire scl_fall;
	wire sda_lvl;
	wire sda_rise;
	wire sda_fall;
	wire start_det;
	wire stop_det;
	reg [31:0] init_cnt_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] bit_cnt_reg;
	reg [3:0] bit_cnt_next;
	reg [7:0] shift_reg;
	reg [7:0] shift_next;
	reg drive_low_reg;
	reg drive_low_next;
	reg got_data_reg;
	reg got_data_next;
	reg commit_next;
	// Last complete data byte, safe from the stop's own clock pulse
	reg [7:0] hold_reg;
	reg [7:0] hold_next;

	ebr_sync u_scl (
		.clk(clk),
		.rstn(rstn),
		.pin_in(scl_in),
		.level_reg(scl_lvl),
		.rise(scl_rise),
		.fall(scl_fall)
	);

	ebr_sync u_sda (
		.clk(clk),
		.rstn(rstn),
		.pin_in(sda_in),
		.level_reg(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// conditions seen in any state once init_done is set
	// Sampled only while our own drive is off, so own edges are never misread
	assign start_det = sda_fall & scl_lvl & ~drive_low_reg;
	assign stop_det = sda_rise & scl_lvl & ~drive_low_reg;

	// interval counter holds the bus off
	always @(posedge clk) begin
		if (!rstn) begin
			init_cnt_reg <= 32'h0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_cnt_reg <= init_cnt_reg + 32'h1;
			if (init_cnt_reg >= INIT_CYCLES - 1)
				init_done <= 1'b1;
		end
	end

	// Protocol next state
	always @* begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		drive_low_next = drive_low_reg;
		got_data_next = got_data_reg;
		commit_next = 1'b0;
		hold_next = hold_reg;
		if (!init_done) begin
			state_next = `EBR_ST_STANDBY;
			drive_low_next = 1'b0;
		end else if (start_det) begin
			state_next = `EBR_ST_ADDR;
			bit_cnt_next = 4'h0;
			got_data_next = 1'b0;
			drive_low_next = 1'b0;
		end else if (stop_det) begin
			// stop after data commits a write
			commit_next = got_data_reg;
			state_next = `EBR_ST_STANDBY;
			bit_cnt_next = 4'h0;
			got_data_next = 1'b0;
			drive_low_next = 1'b0;
		end else begin
			// state only moves with clock edges
			case (state_reg)
				`EBR_ST_ADDR, `EBR_ST_WRITE: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_lvl};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == `EBR_BYTE_BITS) begin
						bit_cnt_next = 4'h0;
						if (state_reg == `EBR_ST_WRITE) begin
							got_data_next = 1'b1;
							hold_next = shift_reg;
							state_next = `EBR_ST_WRITE_ACK;
							drive_low_next = 1'b1;
						end else if (shift_reg[7:1] == DEV_ADDR) begin
							state_next = `EBR_ST_ADDR_ACK;
							drive_low_next = 1'b1;
						end else begin
							state_next = `EBR_ST_IGNORE;
						end
					end
				end
				`EBR_ST_ADDR_ACK, `EBR_ST_WRITE_ACK: begin
					// acknowledge held low until falling edge
					if (scl_fall) begin
						if (state_reg == `EBR_ST_ADDR_ACK && shift_reg[0]) begin
							state_next = `EBR_ST_READ;
							shift_next = READ_BYTE;
							drive_low_next = ~READ_BYTE[7];
						end else begin
							state_next = `EBR_ST_WRITE;
							drive_low_next = 1'b0;
						end
					end
				end
				`EBR_ST_READ: begin
					if (scl_fall) begin
						bit_cnt_next = bit_cnt_reg + 4'h1;
						shift_next = {shift_reg[6:0], 1'b1};
						if (bit_cnt_reg == `EBR_BYTE_BITS - 4'h1) begin
							state_next = `EBR_ST_READ_ACK;
							drive_low_next = 1'b0;
						end else begin
							drive_low_next = ~shift_reg[6];
						end
					end
				end
				`EBR_ST_READ_ACK: begin
					// master high at acknowledge ends output
					if (scl_rise) begin
						got_data_next = ~sda_lvl;
					end else if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (got_data_reg) begin
							state_next = `EBR_ST_READ;
							shift_next = READ_BYTE;
							drive_low_next = ~READ_BYTE[7];
						end else begin
							state_next = `EBR_ST_IGNORE;
						end
						got_data_next = 1'b0;
					end
				end
				`EBR_ST_IGNORE: begin
					drive_low_next = 1'b0;
				end
				default: begin
					state_next = `EBR_ST_STANDBY;
				end
			endcase
		end
	end

	// standby after init and on reset
	always @(posedge clk) begin
		if (!rstn) begin
			state_reg <= `EBR_ST_STANDBY;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			drive_low_reg <= 1'b0;
			got_data_reg <= 1'b0;
			hold_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			drive_low_reg <= drive_low_next;
			got_data_reg <= got_data_next;
			hold_reg <= hold_next;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			standby <= 1'b1;
			wr_commit <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			sda_out <= 1'b0;
			sda_oe <= drive_low_next;
			standby <= (state_next == `EBR_ST_STANDBY);
			wr_commit <= commit_next;
			if (commit_next)
				wr_data <= hold_reg; // Stop's SCL rise has shifted shift_reg
		end
	end
endmodule

/* File: dv/ebr_props.sv */
`timescale 1ns/1ps
module ebr_props #(
	parameter INIT_CYCLES = 4000
) (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Bus pins
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	// Status
	input wire init_done,
	input wire standby,
	input wire wr_commit,
	input wire [7:0] wr_data
);
	reg [15:0] cnt_reg;
	// Cycles since reset release
	always @(posedge clk) begin
		if (!rstn)
			cnt_reg <= 16'h0;
		else if (cnt_reg != 16'hFFFF)
			cnt_reg <= cnt_reg + 16'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_od; sda_oe |-> sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("high drive");
	property p_quiet; !init_done |-> !sda_oe; endproperty
	a_quiet: assert property (p_quiet) else $error("drive in init");
	property p_len; $rose(init_done) |-> cnt_reg == INIT_CYCLES; endproperty
	a_len: assert property (p_len) else $error("init length");
	property p_hold; init_done |=> init_done; endproperty
	a_hold: assert property (p_hold) else $error("init lost");
	property p_stby; $rose(init_done) |-> standby; endproperty
	a_stby: assert property (p_stby) else $error("no standby");
	property p_pulse; wr_commit |=> !wr_commit; endproperty
	a_pulse: assert property (p_pulse) else $error("long commit");
	property p_stop; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] standby; endproperty
	a_stop: assert property (p_stop) else $error("stop missed");
	property p_low; $changed(sda_oe) |-> !scl_in; endproperty
	a_low: assert property (p_low) else $error("drive at clock high");
	cover property (wr_commit);
	cover property ($rose(sda_oe));
	cover property ($rose(init_done));
endmodule
bind ebr_core ebr_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (.clk(clk), .rstn(rstn),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.init_done(init_done), .standby(standby), .wr_commit(wr_commit), .wr_data(wr_data));

/* File: dv/ebr_master.sv */
`timescale 1ns/1ps
module ebr_master (
	// Clock and resolved data wire
	input wire clk,
	input wire sda,
	// Driven bus lines
	output reg scl = 1'b1,
	output reg sda_m = 1'b1
);
	task wt(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task start;
		wt(4);
		sda_m = 1'b1;
		wt(1);
		scl = 1'b1;
		wt(4);
		sda_m = 1'b0;
		wt(4);
		scl = 1'b0;
	endtask
	task stop;
		wt(4);
		sda_m = 1'b0;
		wt(1);
		scl = 1'b1;
		wt(4);
		sda_m = 1'b1;
		wt(4);
	endtask
	// One bit, wire level sampled late in high phase
	task bit_t(input b, output s);
		wt(4);
		sda_m = b;
		wt(1);
		scl = 1'b1;
		wt(3);
		s = sda;
		scl = 1'b0;
	endtask
	// Byte plus acknowledge slot, MSB first
	task xfer(input [8:0] d, output [8:0] q);
		integer i;
		for (i = 8; i >= 0; i = i - 1)
			bit_t(d[i], q[i]);
	endtask
	// dummy clocks, start at once, then stop
	task recover;
		reg s;
		start;
		repeat (9) bit_t(1'b1, s);
		start;
		stop;
	endtask
endmodule

/* File: dv/ebr_core_bench.sv */
`timescale 1ns/1ps
module ebr_core_bench;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [7:0] exp_q[$];
	reg [7:0] dat;
	reg [8:0] r;
	integer mismatches = 0;
	integer checks_done = 0;
	integer cyc = 0;
	integer seed = 32'hE0F43D1C;
	wire scl, sda_m, sda_out, sda_oe, init_done, standby, wr_commit;
	wire [7:0] wr_data;
	// Pulled-up wire, device only pulls low
	wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
	ebr_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	ebr_core #(.INIT_CYCLES(20)) dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .init_done(init_done), .standby(standby),
		.wr_commit(wr_commit), .wr_data(wr_data));
	// Clock
	initial forever #12.5 clk = ~clk;
	// Shared tally behind every compare kind
	task tally(input [8:0] e, input [8:0] g);
		checks_done = checks_done + 1;
		if (e !== g) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask
	// Bus transfer: byte plus acknowledge slot
	task cmp_bus(input [8:0] e, input [8:0] g);
		tally(e, g);
	endtask
	// Committed write byte
	task cmp_commit(input [8:0] e, input [7:0] g);
		tally(e, {1'b0, g});
	endtask
	// Status level or count
	task cmp_state(input [8:0] e, input [8:0] g);
		tally(e, g);
	endtask
	task complete_run;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Timeout and commit watcher, outputs settled at the falling edge
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			complete_run;
		end
		if (wr_commit === 1'b1)
			cmp_commit(exp_q.size() ? {1'b0, exp_q.pop_front()} : 9'h1XX, wr_data);
	end
	// Stimulus
	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		m.start;
		m.xfer({8'hA0, 1'b1}, r);
		cmp_bus({8'hA0, 1'b1}, r);
		m.stop;
		while (init_done !== 1'b1)
			@(negedge clk);
		m.recover;
		repeat (3) begin
			dat = $random(seed);
			exp_q.push_back(dat);
			m.start;
			m.xfer({8'hA0, 1'b1}, r);
			cmp_bus({8'hA0, 1'b0}, r);
			m.xfer({dat, 1'b1}, r);
			cmp_bus({dat, 1'b0}, r);
			m.stop;
			// Two-byte read, master acks the first
			m.start;
			m.xfer({8'hA1, 1'b1}, r);
			m.xfer(9'h1FE, r);
			cmp_bus({8'hA5, 1'b0}, r);
			m.xfer(9'h1FF, r);
			cmp_bus({8'hA5, 1'b1}, r);
			m.stop;
			// Stuck on a zero read bit, then recovery
			m.start;
			m.xfer({8'hA1, 1'b1}, r);
			m.bit_t(1'b1, r[0]);
			m.recover;
			cmp_state(9'h001, {8'h00, standby});
			// Aborted byte, no commit expected
			m.start;
			m.xfer({8'hA0, 1'b1}, r);
			m.bit_t(dat[0], r[0]);
			m.stop;
			cmp_state(9'h001, {8'h00, standby});
		end
		repeat (20) @(negedge clk);
		cmp_state(9'h000, 9'(exp_q.size()));
		complete_run;
	end
endmodule
